// *** core/phy_cfg_consts.svh ***
// Offsets, field positions, reset values and timing counts of the config bank
`ifndef PHY_CFG_CONSTS_SVH
`define PHY_CFG_CONSTS_SVH

// Register indexes; byte address is four times the index
`define DCFG_IDX       12'h01a
`define TCTL_IDX       12'h01e
`define DCFG_ADDR      (`DCFG_IDX << 2)
`define TCTL_ADDR      (`TCTL_IDX << 2)

// Field positions
`define DCFG_DRV_BIT   11
`define DCFG_SYM_BIT   9
`define DCFG_WMASK     16'h0a00
`define TCTL_TLP_BIT   12
`define TCTL_RISE_LO   10
`define TCTL_RISE_HI   11

// Reset values
`define DCFG_RESET     16'h0000
`define TCTL_RESET     16'h0000

// Timing
`define CLK_PERIOD_NS  25
`define STRETCH_MS     30
`define STRETCH_CYC    ((`STRETCH_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// *** core/phy_cfg_pkg.sv ***
// Types shared by the vendor configuration bank
package phy_cfg_pkg;

  // LED display settings
  typedef enum logic [3:0] {
    LED_SPEED    = 4'h0,
    LED_TX       = 4'h1,
    LED_RX       = 4'h2,
    LED_COL      = 4'h3,
    LED_LINK     = 4'h4,
    LED_DUPLEX   = 4'h5,
    LED_UNUSED6  = 4'h6,
    LED_ACT      = 4'h7,
    LED_TEST_ON  = 4'h8,
    LED_TEST_OFF = 4'h9,
    LED_BLINK_F  = 4'ha,
    LED_BLINK_S  = 4'hb,
    LED_LINK_RX  = 4'hc,
    LED_LINK_ACT = 4'hd,
    LED_DUP_COL  = 4'he,
    LED_UNUSEDF  = 4'hf
  } led_mode_e;

  // Start-up sequence: strap capture then normal running
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN   = 2'b10
  } cfg_state_e;

endpackage

// *** core/led_combo.sv ***
// One LED driver with event stretching and combined display settings
`timescale 1ns/100ps
`default_nettype none
`include "phy_cfg_consts.svh"

module led_combo #(
  parameter int unsigned STRETCH_CYC = `STRETCH_CYC
) (
  input  wire logic                   pclk,       // Clock
  input  wire logic                   presetn,    // Async reset, low
  input  wire phy_cfg_pkg::led_mode_e mode,       // Display setting
  input  wire logic                   stretch_en, // Pulse-stretch enable
  input  wire logic                   speed_100,  // Speed status
  input  wire logic                   link_up,    // Link status
  input  wire logic                   full_dup,   // Duplex status
  input  wire logic                   tx_evt,     // Transmit event
  input  wire logic                   rx_evt,     // Receive event
  input  wire logic                   col_evt,    // Collision event
  input  wire logic                   blink_ph,   // Test blink phase
  output logic                        led_r       // LED, high = on
);
  import phy_cfg_pkg::*;

  logic [31:0] cnt_r;
  logic        evt;
  logic        primary;
  logic        combo;
  logic        led_nxt;

  // Event source and primary indication per setting
  always_comb begin
    combo   = 1'b0;
    primary = 1'b0;
    evt     = 1'b0;
    unique case (mode)
      LED_TX:       evt = tx_evt;
      LED_RX:       evt = rx_evt;
      LED_COL:      evt = col_evt;
      LED_ACT:      evt = tx_evt | rx_evt;
      LED_LINK_RX: begin
        combo = 1'b1; primary = link_up; evt = rx_evt;
      end
      LED_LINK_ACT: begin
        combo = 1'b1; primary = link_up; evt = tx_evt | rx_evt;
      end
      LED_DUP_COL: begin
        combo = 1'b1; primary = full_dup; evt = col_evt;
      end
      default: ;
    endcase
  end

  // Stretch counter, reloaded by each event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0;
    end else if (evt) begin
      cnt_r <= STRETCH_CYC;
    end else if (cnt_r != 32'h0) begin
      cnt_r <= cnt_r - 32'h1;
    end
  end

  // Combined settings always stretch; single ones only when enabled
  always_comb begin
    unique case (mode)
      LED_SPEED:    led_nxt = speed_100;
      LED_LINK:     led_nxt = link_up;
      LED_DUPLEX:   led_nxt = full_dup;
      LED_TEST_ON:  led_nxt = 1'b1;
      LED_BLINK_F,
      LED_BLINK_S:  led_nxt = blink_ph;
      LED_TX, LED_RX, LED_COL, LED_ACT:
        led_nxt = stretch_en ? (evt | cnt_r != 32'h0) : evt;
      LED_LINK_RX, LED_LINK_ACT, LED_DUP_COL:
        led_nxt = primary ^ (evt | cnt_r != 32'h0);
      default:      led_nxt = 1'b0;
    endcase
  end

  // LED flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_r <= 1'b0;
    end else begin
      led_r <= led_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_combo_stretch;
    @(posedge pclk) disable iff (!presetn)
      (combo && evt && !stretch_en && $stable(mode))
        ##1 ($stable(mode) && $stable(primary) && !evt)
      |=> (led_r == !primary);
  endproperty
  a_combo_stretch: assert property (p_combo_stretch)
    else $error("combined LED event not stretched");

  property p_dup_solid;
    @(posedge pclk) disable iff (!presetn)
      (mode == LED_DUP_COL && full_dup && !col_evt && cnt_r == 32'h0)
      |=> led_r;
  endproperty
  a_dup_solid: assert property (p_dup_solid)
    else $error("full duplex LED not solid on");

  property p_col_toggle;
    @(posedge pclk) disable iff (!presetn)
      (mode == LED_DUP_COL && col_evt) |=> (led_r == !$past(full_dup));
  endproperty
  a_col_toggle: assert property (p_col_toggle)
    else $error("collision did not change LED state");

  property p_link_blink;
    @(posedge pclk) disable iff (!presetn)
      (mode == LED_LINK_RX && link_up && rx_evt) |=> !led_r;
  endproperty
  a_link_blink: assert property (p_link_blink)
    else $error("receive did not blink link LED");

endmodule

`default_nettype wire

// *** core/phy_vendor_config_regs.sv ***
// Vendor configuration bank of the PHY on APB, with LED and MII controls
`timescale 1ns/100ps
`default_nettype none
`include "phy_cfg_consts.svh"

// Operation
// - Combined LED settings always stretch events
// - Secondary event flips LED over link
// - Duplex-collision setting: solid on at full duplex
// - Duplex-collision setting: collision flips the LED
// - Symbol-error bit maps symbol errors onto receive-error
// - Drive-strength bit selects increased MII drive
// - Low-power bit forces idle zero-differential transmitter
// - Two-bit rise-time field, default from pins
module phy_vendor_config_regs #(
  parameter int unsigned STRETCH_CYC = `STRETCH_CYC
) (
  input  wire logic                   pclk,              // Clock
  input  wire logic                   presetn,           // Async reset, low
  input  wire logic                   psel,              // APB select
  input  wire logic                   penable,           // APB enable
  input  wire logic                   pwrite,            // APB direction
  input  wire logic [11:0]            paddr,             // APB byte address
  input  wire logic [31:0]            pwdata,            // APB write data
  output logic                        pready,            // APB ready
  output logic [31:0]                 prdata,            // APB read data
  output logic                        pslverr,           // APB error
  input  wire logic [1:0]             tx_edge_rate_pins, // Rise-time straps
  input  wire logic                   rx_er_in,          // Normal receive err
  input  wire logic                   sym_err_in,        // Symbol error
  output logic                        rx_er_out,         // Receive err to MAC
  output logic                        mii_drive_high,    // Increased drive
  output logic                        tx_low_power,      // Tx low power
  output logic                        tx_zero_diff,      // Zero-diff output
  output logic [1:0]                  tx_rise_sel,       // Rise-time select
  input  wire phy_cfg_pkg::led_mode_e led_mode,          // LED setting
  input  wire logic                   led_stretch_en,    // Pulse stretch
  input  wire logic                   speed_100,         // Speed status
  input  wire logic                   link_up,           // Link status
  input  wire logic                   full_dup,          // Duplex status
  input  wire logic                   tx_evt,            // Transmit event
  input  wire logic                   rx_evt,            // Receive event
  input  wire logic                   col_evt,           // Collision event
  input  wire logic                   blink_ph,          // Test blink phase
  output logic                        led_out            // LED, high = on
);
  import phy_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Register storage and bus decode
  // ----------------------------------------------------------------
  cfg_state_e  state_r;
  logic [15:0] dcfg_r;
  logic [15:0] tctl_r;
  logic        setup;
  logic        wr_done;
  logic        hit_d;
  logic        hit_t;

  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite;
  assign hit_d   = paddr == `DCFG_ADDR;
  assign hit_t   = paddr == `TCTL_ADDR;

  // Start-up: catch the strap pins at the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_STRAP;
    end else begin
      unique case (state_r)
        ST_STRAP: state_r <= ST_RUN;
        ST_RUN:   state_r <= ST_RUN;
      endcase
    end
  end

  // Digital config: only drive and symbol-error bits are writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcfg_r <= `DCFG_RESET;
    end else if (wr_done && hit_d) begin
      dcfg_r <= pwdata[15:0] & `DCFG_WMASK;
    end
  end

  // Transmit control: all bits stored, rise-time default from pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctl_r <= `TCTL_RESET;
    end else if (state_r == ST_STRAP) begin
      tctl_r[`TCTL_RISE_HI:`TCTL_RISE_LO] <= tx_edge_rate_pins;
    end else if (wr_done && hit_t) begin
      tctl_r <= pwdata[15:0];
    end
  end

  // APB answer: one access cycle, data and error set at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !(hit_d || hit_t);
      if (setup && !pwrite) begin
        prdata <= hit_d ? {16'h0, dcfg_r} :
                  hit_t ? {16'h0, tctl_r} : 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Functional outputs
  // ----------------------------------------------------------------
  // Receive-error source and transmitter controls, reserved bits unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_er_out      <= 1'b0;
      mii_drive_high <= 1'b0;
      tx_low_power   <= 1'b0;
      tx_zero_diff   <= 1'b0;
      tx_rise_sel    <= 2'h0;
    end else begin
      rx_er_out      <= dcfg_r[`DCFG_SYM_BIT] ? sym_err_in : rx_er_in;
      mii_drive_high <= dcfg_r[`DCFG_DRV_BIT];
      tx_low_power   <= tctl_r[`TCTL_TLP_BIT];
      tx_zero_diff   <= tctl_r[`TCTL_TLP_BIT];
      tx_rise_sel    <= tctl_r[`TCTL_RISE_HI:`TCTL_RISE_LO];
    end
  end

  // LED driver
  led_combo #(
    .STRETCH_CYC (STRETCH_CYC)
  ) u_led (
    .pclk       (pclk),
    .presetn    (presetn),
    .mode       (led_mode),
    .stretch_en (led_stretch_en),
    .speed_100  (speed_100),
    .link_up    (link_up),
    .full_dup   (full_dup),
    .tx_evt     (tx_evt),
    .rx_evt     (rx_evt),
    .col_evt    (col_evt),
    .blink_ph   (blink_ph),
    .led_r      (led_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sym_map;
    @(posedge pclk) disable iff (!presetn)
      dcfg_r[`DCFG_SYM_BIT] |=> (rx_er_out == $past(sym_err_in));
  endproperty
  a_sym_map: assert property (p_sym_map)
    else $error("symbol error not mapped to receive error");

  property p_sym_normal;
    @(posedge pclk) disable iff (!presetn)
      !dcfg_r[`DCFG_SYM_BIT] |=> (rx_er_out == $past(rx_er_in));
  endproperty
  a_sym_normal: assert property (p_sym_normal)
    else $error("receive error not passed through");

  property p_drive;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && hit_d) |=> ##1 (mii_drive_high == $past(pwdata[11], 2));
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive strength does not follow write");

  property p_low_power;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && hit_t) |=> ##1
        (tx_low_power == $past(pwdata[12], 2) && tx_zero_diff == tx_low_power);
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power does not follow write");

  property p_strap;
    @(posedge pclk) disable iff (!presetn)
      (state_r == ST_STRAP) |=> ##1 (tx_rise_sel == $past(tx_edge_rate_pins, 2));
  endproperty
  a_strap: assert property (p_strap)
    else $error("rise time default not taken from pins");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_d) |=> (prdata[31:12] == 20'h0 &&
        prdata[10] == 1'b0 && prdata[8:0] == 9'h0);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  // A rise-time write reaches the transmitter select two edges later
  property p_rise;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && hit_t) |=> ##1
        (tx_rise_sel == $past(pwdata[11:10], 2));
  endproperty
  a_rise: assert property (p_rise)
    else $error("rise time select does not follow write");

  // A write to an unmapped address must leave both registers alone
  property p_unmapped_drop;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && !(hit_d || hit_t)) |=>
        ($stable(dcfg_r) && $stable(tctl_r));
  endproperty
  a_unmapped_drop: assert property (p_unmapped_drop)
    else $error("unmapped write changed a register");

  // An unmapped read answers with an error and zero data
  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && !(hit_d || hit_t)) |=>
        (pready && pslverr && prdata == 32'h0);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped read not refused");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
      setup |=> (pready && psel && penable) ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not one cycle after setup");

endmodule

`default_nettype wire

// *** dv/mac_rx_model.sv ***
// Receiving side of the MAC: counts cycles with receive-error raised
`timescale 1ns/100ps
`default_nettype none
module mac_rx_model (
  input  wire logic       pclk,     // Clock
  input  wire logic       presetn,  // Async reset, low
  input  wire logic       rx_er,    // Receive error from the PHY
  output logic      [7:0] er_cnt_r  // Error cycles seen
);
  // One count per cycle with the error line high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      er_cnt_r <= 8'h00;
    end else if (rx_er) begin
      er_cnt_r <= er_cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** dv/phy_vendor_config_regs_tb_top.sv ***
// Testbench of the vendor configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "phy_cfg_consts.svh"
module phy_vendor_config_regs_tb_top;
  import phy_cfg_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, rx_er_out, mii_drive_high, tx_low_power;
  logic        tx_zero_diff, led_out, e;
  logic        rx_er_in = 0, sym_err_in = 0, led_stretch_en = 0;
  logic        link_up = 0, full_dup = 0, rx_evt = 0, col_evt = 0;
  logic        tx_evt = 0;
  logic [1:0]  pins = 2'b10, tx_rise_sel;
  logic [7:0]  er_cnt;
  led_mode_e   led_mode = LED_SPEED;
  int          err_count = 0, checks_done = 0, cyc = 0, d;
  localparam logic [11:0] DA = `DCFG_ADDR;
  localparam logic [11:0] TA = `TCTL_ADDR;

  always #12.5 pclk = ~pclk;

  phy_vendor_config_regs #(.STRETCH_CYC(8)) i_phy_vendor_config_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tx_edge_rate_pins(pins),
    .rx_er_in(rx_er_in), .sym_err_in(sym_err_in), .rx_er_out(rx_er_out),
    .mii_drive_high(mii_drive_high), .tx_low_power(tx_low_power),
    .tx_zero_diff(tx_zero_diff), .tx_rise_sel(tx_rise_sel),
    .led_mode(led_mode), .led_stretch_en(led_stretch_en),
    .speed_100(1'b0), .link_up(link_up), .full_dup(full_dup),
    .tx_evt(tx_evt), .rx_evt(rx_evt), .col_evt(col_evt), .blink_ph(1'b0),
    .led_out(led_out));

  mac_rx_model i_mac_rx_model (
    .pclk(pclk), .presetn(presetn), .rx_er(rx_er_out), .er_cnt_r(er_cnt));

  //--------------------------------------------------------------------
  // Tasks
  //--------------------------------------------------------------------
  // Ends the run with the counts and the verdict
  task automatic final_report();
    $display("TB: checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares one result against its expected value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, then takes data and error
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Raises symbol and receive errors for n cycles, counts what the MAC saw
  task automatic burst(input logic s, input logic r, input int n);
    int c0;
    c0 = er_cnt;
    @(posedge pclk);
    sym_err_in <= s;
    rx_er_in <= r;
    repeat (n) @(posedge pclk);
    sym_err_in <= 1'b0;
    rx_er_in <= 1'b0;
    repeat (4) @(posedge pclk);
    d = er_cnt - c0;
  endtask

  // Pulses events {tx, rx, col} under setting m; LED flips from base,
  // stays flipped while stretched (st), then recovers
  task automatic led_case(input led_mode_e m, input logic [2:0] ev,
                          input logic base, input logic st);
    @(posedge pclk);
    led_mode <= m;
    repeat (3) @(posedge pclk);
    chk(led_out, base);
    {tx_evt, rx_evt, col_evt} <= ev;
    @(posedge pclk);
    {tx_evt, rx_evt, col_evt} <= 3'b000;
    @(posedge pclk);
    chk(led_out, !base);
    repeat (3) @(posedge pclk);
    chk(led_out, base ^ st);
    repeat (20) @(posedge pclk);
    chk(led_out, base);
  endtask

  // Cuts a hung run short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  //--------------------------------------------------------------------
  // Tests
  //--------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, DA, 0);
    chk(q, `DCFG_RESET);
    apb(0, TA, 0);
    chk(q, 32'h0800);
    chk(tx_rise_sel, 2'b10);
    chk({mii_drive_high, tx_low_power, tx_zero_diff}, 0);
    $display("TB: reset values done");
    apb(1, DA, 32'hffff);
    apb(0, DA, 0);
    chk(q, 32'h0a00);
    repeat (2) @(posedge pclk);
    chk(mii_drive_high, 1);
    burst(1, 0, 3);
    chk(d, 3);
    apb(1, DA, 0);
    repeat (2) @(posedge pclk);
    chk(mii_drive_high, 0);
    burst(1, 0, 3);
    chk(d, 0);
    burst(0, 1, 2);
    chk(d, 2);
    $display("TB: digital config done");
    apb(1, TA, 32'h1000);
    repeat (2) @(posedge pclk);
    chk({tx_low_power, tx_zero_diff, tx_rise_sel}, 4'hc);
    for (int r = 0; r < 4; r++) begin
      apb(1, TA, 32'(r) << 10);
      repeat (2) @(posedge pclk);
      chk({tx_low_power, tx_zero_diff, tx_rise_sel}, r);
    end
    apb(1, TA, 32'hffff);
    apb(0, TA, 0);
    chk(q, 32'hffff);
    apb(0, 12'h070, 0);
    chk({q[30:0], e}, 1);
    apb(1, 12'h070, 0);
    chk(e, 1);
    apb(0, TA, 0);
    chk(q, 32'hffff);
    $display("TB: transmit control done");
    full_dup <= 1'b1;
    link_up <= 1'b1;
    led_case(LED_DUP_COL, 3'b001, 1, 1);
    led_case(LED_LINK_RX, 3'b010, 1, 1);
    led_case(LED_LINK_ACT, 3'b100, 1, 1);
    led_case(LED_RX, 3'b010, 0, 0);
    led_stretch_en <= 1'b1;
    led_case(LED_RX, 3'b010, 0, 1);
    led_case(LED_LINK_ACT, 3'b010, 1, 1);
    full_dup <= 1'b0;
    led_case(LED_DUP_COL, 3'b001, 0, 1);
    $display("TB: LED settings done");
    @(posedge pclk);
    presetn <= 1'b0;
    pins <= 2'b01;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(tx_rise_sel, 2'b01);
    chk({mii_drive_high, tx_low_power, tx_zero_diff}, 0);
    apb(0, TA, 0);
    chk(q, 32'h0400);
    apb(0, DA, 0);
    chk(q, `DCFG_RESET);
    $display("TB: mid-run reset done");
    final_report();
  end
endmodule
`default_nettype wire
